// ---- include/pfi_pkg.sv ----
// Constants and types for the pin function select and IRQ input block
package pfi_pkg;
  localparam int unsigned NUM_PINS   = 32;
  localparam int unsigned NUM_IRQ    = 16;
  localparam int unsigned NUM_FUNC   = 32;
  localparam int unsigned FSEL_W     = 5;
  localparam int unsigned NUM_RATES  = 4;
  localparam int unsigned IRQCR_W    = 8;

  // Register byte offsets
  localparam logic [11:0] PFS_BASE_OFS   = 12'h000;
  localparam logic [11:0] PFS_LAST_OFS   = 12'h07C;
  localparam logic [11:0] WPROT_OFS      = 12'h100;
  localparam logic [11:0] IRQCR_BASE_OFS = 12'h200;
  localparam logic [11:0] IRQCR_LAST_OFS = 12'h23C;
  localparam logic [11:0] PIN_LEVEL_OFS  = 12'h300;

  // pin_function_select_reg fields
  localparam int unsigned PFS_ODATA_BIT = 0;
  localparam int unsigned PFS_DIR_BIT   = 2;
  localparam int unsigned PFS_IRQ_INPUT_SEL_BIT  = 14;
  localparam int unsigned PFS_ANALOG_INPUT_SEL_BIT  = 15;
  localparam int unsigned PFS_PMR_BIT   = 16;
  localparam int unsigned PFS_FSEL_LSB  = 24;
  localparam logic [31:0] PFS_WMASK     = 32'h1F01_C005;
  localparam logic [31:0] PFS_RESET     = 32'h0000_0000;

  // pin_cfg_write_protect_reg fields
  localparam int unsigned WPROT_EN_BIT  = 6;
  localparam logic        WPROT_RESET   = 1'b0;

  // irq_control_reg fields
  localparam int unsigned TRIG_LSB      = 0;
  localparam int unsigned RATE_LSB      = 4;
  localparam int unsigned IRQ_FILTER_EN_BIT     = 7;
  localparam logic [7:0]  IRQCR_WMASK   = 8'hB3;
  localparam logic [7:0]  IRQCR_RESET   = 8'h00;

  typedef enum logic [1:0] {
    TRIG_FALL = 2'b00,
    TRIG_RISE = 2'b01,
    TRIG_BOTH = 2'b10,
    TRIG_LOW  = 2'b11
  } pfi_trig_t;

  // Sample strobe divider
  localparam logic [5:0]  DIV_RESET     = 6'h00;
  localparam logic [5:0]  DIV8_MASK     = 6'h07;
  localparam logic [5:0]  DIV32_MASK    = 6'h1F;
  localparam logic [5:0]  DIV64_MASK    = 6'h3F;
  localparam int unsigned FILT_SAMPLES  = 3;
  localparam logic        LEVEL_IDLE    = 1'b1;

  // AHB-Lite
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : pfi_pkg

// ---- include/pfi_strobe_if.sv ----
// Sample strobe bundle from the divider to the IRQ channels
`timescale 1ns/1ps
`default_nettype none
interface pfi_strobe_if;
  logic [pfi_pkg::NUM_RATES-1:0] strobe;
  modport src (output strobe);
  modport snk (input  strobe);
endinterface : pfi_strobe_if
`default_nettype wire

// ---- design/pfi_sample_div.sv ----
// Divider making the PCLK, /8, /32 and /64 filter sample strobes
`timescale 1ns/1ps
`default_nettype none
module pfi_sample_div
  import pfi_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  pfi_strobe_if.src   sb
);
  logic [5:0]           cnt_reg;
  logic [5:0]           cnt_next;
  logic [NUM_RATES-1:0] strobe_reg;
  logic [NUM_RATES-1:0] strobe_next;

  always_comb
  begin
    cnt_next       = cnt_reg + 6'h01;
    strobe_next[0] = 1'b1;
    strobe_next[1] = (cnt_reg & DIV8_MASK) == DIV8_MASK;
    strobe_next[2] = (cnt_reg & DIV32_MASK) == DIV32_MASK;
    strobe_next[3] = (cnt_reg & DIV64_MASK) == DIV64_MASK;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg    <= DIV_RESET;
      strobe_reg <= '0;
    end
    else
    begin
      cnt_reg    <= cnt_next;
      strobe_reg <= strobe_next;
    end
  end

  assign sb.strobe = strobe_reg;

  strobe8_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    strobe_reg[1] |=> !strobe_reg[1] [*7] ##1 strobe_reg[1])
    else $error("divide-by-8 strobe period is not 8");
endmodule : pfi_sample_div
`default_nettype wire

// ---- design/pfi_irq_chan.sv ----
// One external IRQ input: synchroniser, digital filter and trigger detect
`timescale 1ns/1ps
`default_nettype none
module pfi_irq_chan
  import pfi_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       level_in,
  input  wire logic       filter_en_in,
  input  wire logic [1:0] rate_sel_in,
  input  wire pfi_trig_t  trig_in,
  pfi_strobe_if.snk       sb,
  output logic            event_out
);
  logic                    sync1_reg;
  logic                    sync2_reg;
  logic [FILT_SAMPLES-2:0] hist_reg;
  logic [FILT_SAMPLES-2:0] hist_next;
  logic                    filt_reg;
  logic                    filt_next;
  logic                    prev_reg;
  logic                    prev_next;
  logic                    event_reg;
  logic                    event_next;
  logic                    strobe;
  logic                    level;

  always_comb
  begin
    strobe    = sb.strobe[rate_sel_in];
    hist_next = hist_reg;
    filt_next = filt_reg;
    if (strobe)
    begin
      hist_next = {hist_reg[FILT_SAMPLES-3:0], sync2_reg};
      // change only after three equal samples
      if (hist_reg == {(FILT_SAMPLES-1){sync2_reg}})
        filt_next = sync2_reg;
    end
    level     = filter_en_in ? filt_reg : sync2_reg;
    prev_next = level;
    unique case (trig_in)
      TRIG_FALL: event_next = prev_reg & ~level;
      TRIG_RISE: event_next = ~prev_reg & level;
      TRIG_BOTH: event_next = prev_reg ^ level;
      TRIG_LOW:  event_next = ~level;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_reg <= LEVEL_IDLE;
      sync2_reg <= LEVEL_IDLE;
      hist_reg  <= {(FILT_SAMPLES-1){LEVEL_IDLE}};
      filt_reg  <= LEVEL_IDLE;
      prev_reg  <= LEVEL_IDLE;
      event_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= level_in;
      sync2_reg <= sync1_reg;
      hist_reg  <= hist_next;
      filt_reg  <= filt_next;
      prev_reg  <= prev_next;
      event_reg <= event_next;
    end
  end

  assign event_out = event_reg;

  logic rise_mode;
  assign rise_mode = (trig_in == TRIG_RISE) && !filter_en_in;

  filt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(filt_reg) |-> $past(strobe) && ($past(sync2_reg) == filt_reg)
                           && ($past(hist_reg) == {(FILT_SAMPLES-1){filt_reg}}))
    else $error("filter output changed without three equal samples");

  rise_bypass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_reg && $past(rise_mode) && $past(rise_mode, 2)
      |-> $past(sync2_reg) && !$past(sync2_reg, 2))
    else $error("rising event without a rising synchronised edge");

  low_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (trig_in == TRIG_LOW) && !filter_en_in && !sync2_reg |=> event_reg)
    else $error("low level not reported");

  filt_change_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    filter_en_in && $changed(filt_reg));
endmodule : pfi_irq_chan
`default_nettype wire

// ---- design/pfi_top.sv ----
// Pin function select, write protect, AHB-Lite registers and IRQ inputs
// Operation
// - Each pin has own function select register
// - Select registers write-blocked until unlocked
// - IRQ and its standby twin share interrupt
// - Standby-capable inputs raise a wake event
// - IRQ select bit makes pin interrupt input
// - Peripheral and IRQ may coexist on pin
// - Low, falling, rising or both edges
// - Filter samples at PCLK /1 /8 /32 /64
// - Pulses under three samples are suppressed
// - Filter enabled per input by its bit
// - Filtering delays detection by filter time
// - All pins come up as inputs
// - Peripheral mode resets to GPIO
// - Direction one is output, zero input
// - Sixteen IRQ inputs with own settings
`timescale 1ns/1ps
`default_nettype none
module pfi_top
  import pfi_pkg::*;
(
  input  wire logic                CLK_SYS_IN,
  input  wire logic                RST_B_IN,
  input  wire logic                HSEL_IN,
  input  wire logic [11:0]         HADDR_IN,
  input  wire logic [1:0]          HTRANS_IN,
  input  wire logic                HWRITE_IN,
  input  wire logic [2:0]          HSIZE_IN,
  input  wire logic [31:0]         HWDATA_IN,
  input  wire logic                HREADY_IN,
  output logic      [31:0]         HRDATA_OUT,
  output logic                     HREADYOUT_OUT,
  output logic                     HRESP_OUT,
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output logic      [NUM_PINS-1:0] PIN_OUT,
  output logic      [NUM_PINS-1:0] PIN_OE_OUT,
  output logic      [NUM_PINS-1:0] ANALOG_SEL_OUT,
  input  wire logic [NUM_FUNC-1:0] PERIPH_DATA_IN,
  input  wire logic [NUM_FUNC-1:0] PERIPH_OE_IN,
  output logic      [NUM_FUNC-1:0] PERIPH_DATA_OUT,
  output logic      [NUM_IRQ-1:0]  IRQ_EVENT_OUT,
  output logic      [NUM_IRQ-1:0]  DS_WAKE_OUT
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  function automatic logic is_pfs(input logic [11:0] a);
    return (a >= PFS_BASE_OFS) && (a <= PFS_LAST_OFS) && (a[1:0] == 2'b00);
  endfunction : is_pfs

  function automatic logic is_irqcr(input logic [11:0] a);
    return (a >= IRQCR_BASE_OFS) && (a <= IRQCR_LAST_OFS) && (a[1:0] == 2'b00);
  endfunction : is_irqcr

  function automatic logic [4:0] pfs_idx(input logic [11:0] a);
    return a[6:2];
  endfunction : pfs_idx

  function automatic logic [3:0] irqcr_idx(input logic [11:0] a);
    return a[5:2];
  endfunction : irqcr_idx

  // Configuration registers
  logic [31:0]        pfs_reg   [NUM_PINS];
  logic [31:0]        pfs_next  [NUM_PINS];
  logic [IRQCR_W-1:0] irqcr_reg [NUM_IRQ];
  logic [IRQCR_W-1:0] irqcr_next[NUM_IRQ];
  logic               wprot_reg;
  logic               wprot_next;

  // Bus data phase state
  logic               wr_pend_reg;
  logic               wr_pend_next;
  logic [11:0]        addr_reg;
  logic [11:0]        addr_next;
  logic [31:0]        hrdata_reg;
  logic [31:0]        hrdata_next;
  logic               ahb_go;
  logic [NUM_PINS-1:0] pin_level_reg;

  assign ahb_go = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

  always_comb
  begin
    pfs_next   = pfs_reg;
    irqcr_next = irqcr_reg;
    wprot_next = wprot_reg;
    if (wr_pend_reg)
    begin
      if (addr_reg == WPROT_OFS)
        wprot_next = HWDATA_IN[WPROT_EN_BIT];
      if (is_pfs(addr_reg) && wprot_reg)
        pfs_next[pfs_idx(addr_reg)] = HWDATA_IN & PFS_WMASK;
      if (is_irqcr(addr_reg))
        irqcr_next[irqcr_idx(addr_reg)] = HWDATA_IN[IRQCR_W-1:0] & IRQCR_WMASK;
    end
  end

  // Read data forwards a write still in its data phase
  always_comb
  begin
    wr_pend_next = ahb_go && HWRITE_IN && (HSIZE_IN == HSIZE_WORD);
    addr_next    = ahb_go ? HADDR_IN : addr_reg;
    hrdata_next  = '0;
    if (ahb_go && !HWRITE_IN)
    begin
      if (is_pfs(HADDR_IN))
        hrdata_next = pfs_next[pfs_idx(HADDR_IN)];
      else if (is_irqcr(HADDR_IN))
        hrdata_next[IRQCR_W-1:0] = irqcr_next[irqcr_idx(HADDR_IN)];
      else if (HADDR_IN == WPROT_OFS)
        hrdata_next[WPROT_EN_BIT] = wprot_next;
      else if (HADDR_IN == PIN_LEVEL_OFS)
        hrdata_next = pin_level_reg;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        pfs_reg[i] <= PFS_RESET;
      for (int i = 0; i < NUM_IRQ; i++)
        irqcr_reg[i] <= IRQCR_RESET;
      wprot_reg   <= WPROT_RESET;
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
      hrdata_reg  <= '0;
    end
    else
    begin
      pfs_reg     <= pfs_next;
      irqcr_reg   <= irqcr_next;
      wprot_reg   <= wprot_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg    <= addr_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  // Pin routing
  logic [NUM_PINS-1:0] pin_out_reg;
  logic [NUM_PINS-1:0] pin_out_next;
  logic [NUM_PINS-1:0] pin_oe_reg;
  logic [NUM_PINS-1:0] pin_oe_next;
  logic [NUM_PINS-1:0] analog_input_sel_reg;
  logic [NUM_PINS-1:0] analog_input_sel_next;
  logic [NUM_FUNC-1:0] pdata_reg;
  logic [NUM_FUNC-1:0] pdata_next;

  always_comb
  begin
    logic [FSEL_W-1:0] fsel_v;
    fsel_v       = '0;
    pin_out_next = '0;
    pin_oe_next  = '0;
    analog_input_sel_next    = '0;
    pdata_next   = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      fsel_v       = pfs_reg[p][PFS_FSEL_LSB +: FSEL_W];
      analog_input_sel_next[p] = pfs_reg[p][PFS_ANALOG_INPUT_SEL_BIT];
      if (pfs_reg[p][PFS_ANALOG_INPUT_SEL_BIT])
      begin
        pin_oe_next[p] = 1'b0;
      end
      else if (pfs_reg[p][PFS_PMR_BIT])
      begin
        pin_out_next[p] = PERIPH_DATA_IN[fsel_v];
        pin_oe_next[p]  = PERIPH_OE_IN[fsel_v];
      end
      else
      begin
        pin_out_next[p] = pfs_reg[p][PFS_ODATA_BIT];
        pin_oe_next[p]  = pfs_reg[p][PFS_DIR_BIT];
      end
      // Duplicate assignment merges by OR
      if (pfs_reg[p][PFS_PMR_BIT])
        pdata_next[fsel_v] = pdata_next[fsel_v] | PIN_IN[p];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_reg   <= '0;
      pin_oe_reg    <= '0;
      analog_input_sel_reg      <= '0;
      pdata_reg     <= '0;
      pin_level_reg <= '0;
    end
    else
    begin
      pin_out_reg   <= pin_out_next;
      pin_oe_reg    <= pin_oe_next;
      analog_input_sel_reg      <= analog_input_sel_next;
      pdata_reg     <= pdata_next;
      pin_level_reg <= PIN_IN;
    end
  end

  // IRQ sources: pin i and its standby twin i+16
  logic [NUM_IRQ-1:0] irq_src;
  logic [NUM_IRQ-1:0] chan_event;
  logic [NUM_IRQ-1:0] wake_reg;
  logic [NUM_IRQ-1:0] wake_next;

  always_comb
  begin
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (pfs_reg[i+NUM_IRQ][PFS_IRQ_INPUT_SEL_BIT])
        irq_src[i] = PIN_IN[i+NUM_IRQ];
      else if (pfs_reg[i][PFS_IRQ_INPUT_SEL_BIT])
        irq_src[i] = PIN_IN[i];
      else
        irq_src[i] = LEVEL_IDLE;
      wake_next[i] = chan_event[i] && pfs_reg[i+NUM_IRQ][PFS_IRQ_INPUT_SEL_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n)
  begin
    if (!rst_n)
      wake_reg <= '0;
    else
      wake_reg <= wake_next;
  end

  pfi_strobe_if strobe_bus ();

  pfi_sample_div u_div (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (rst_n),
    .sb       (strobe_bus)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : g_chan
      pfi_irq_chan u_chan (
        .clk_in       (CLK_SYS_IN),
        .rst_n_in     (rst_n),
        .level_in     (irq_src[g]),
        .filter_en_in (irqcr_reg[g][IRQ_FILTER_EN_BIT]),
        .rate_sel_in  (irqcr_reg[g][RATE_LSB +: 2]),
        .trig_in      (pfi_trig_t'(irqcr_reg[g][TRIG_LSB +: 2])),
        .sb           (strobe_bus),
        .event_out    (chan_event[g])
      );
    end
  endgenerate

  assign HRDATA_OUT      = hrdata_reg;
  assign HREADYOUT_OUT   = rst_n;
  assign HRESP_OUT       = 1'b0;
  assign PIN_OUT         = pin_out_reg;
  assign PIN_OE_OUT      = pin_oe_reg;
  assign ANALOG_SEL_OUT  = analog_input_sel_reg;
  assign PERIPH_DATA_OUT = pdata_reg;
  assign IRQ_EVENT_OUT   = chan_event;
  assign DS_WAKE_OUT     = wake_reg;

  logic [31:0] pin0_cfg;
  logic [31:0] pin16_cfg;
  assign pin0_cfg  = pfs_reg[0];
  assign pin16_cfg = pfs_reg[NUM_IRQ];

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  wprot_block_a: assert property (
    wr_pend_reg && is_pfs(addr_reg) && !wprot_reg |=> pin0_cfg == $past(pin0_cfg))
    else $error("locked select register was written");

  reset_input_a: assert property (disable iff (1'b0)
    !rst_n |=> PIN_OE_OUT == '0)
    else $error("pin driving during reset");

  oe_follow_a: assert property (
    !pin0_cfg[PFS_PMR_BIT] && !pin0_cfg[PFS_ANALOG_INPUT_SEL_BIT] |=> PIN_OE_OUT[0] == $past(pin0_cfg[PFS_DIR_BIT]))
    else $error("pin 0 enable does not follow direction");

  analog_off_a: assert property (
    pin0_cfg[PFS_ANALOG_INPUT_SEL_BIT] |=> !PIN_OE_OUT[0] && ANALOG_SEL_OUT[0])
    else $error("analog pin still driven");

  wake_twin_a: assert property (
    DS_WAKE_OUT[0] |-> $past(IRQ_EVENT_OUT[0]) && $past(pin16_cfg[PFS_IRQ_INPUT_SEL_BIT]))
    else $error("wake without standby twin event");

  read_level_a: assert property (
    ahb_go && !HWRITE_IN && (HADDR_IN == PIN_LEVEL_OFS) |=> HRDATA_OUT == $past(pin_level_reg))
    else $error("pin level read mismatch");

  unlock_c: cover property (wr_pend_reg && (addr_reg == WPROT_OFS) && HWDATA_IN[WPROT_EN_BIT]);
  wake_c: cover property (DS_WAKE_OUT != '0);
endmodule : pfi_top
`default_nettype wire

// ---- verification/pfi_pin_model.sv ----
// External pin sources as seen at the block's pads
`timescale 1ns/1ps
`default_nettype none
module pfi_pin_model
  import pfi_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] ext_level_in,
  input  wire logic [NUM_PINS-1:0] pin_out_in,
  input  wire logic [NUM_PINS-1:0] pin_oe_in,
  output logic      [NUM_PINS-1:0] pin_level_out
);
  // one source per pin
  // Device drive wins over the external source
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      pin_level_out[p] = pin_oe_in[p] ? pin_out_in[p] : ext_level_in[p];
    end
  end
endmodule : pfi_pin_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the pin function and IRQ input block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pfi_pkg::*;
;
  logic        clk    = 1'b0;
  logic        rst_b  = 1'b0;
  logic        hsel   = 1'b0;
  logic [11:0] haddr  = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] ext    = 32'hFFFF_FFFF;
  logic [31:0] pdata  = 32'h0000_0000;
  logic [31:0] poe    = 32'h0000_0000;
  wire  logic [31:0] hrdata, pin_lvl, pout, poe_o, analog_input_sel, pdo;
  wire  logic [15:0] irq, wake;
  wire  logic        hrdy, hresp;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cnt, ds, oth, lat, lat0;
  int          exp_n[4] = '{1, 1, 2, 10};
  int          per[4]   = '{1, 8, 32, 64};

  always #2.5 clk = ~clk;

  pfi_top dut_u (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(HSIZE_WORD), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .PIN_IN(pin_lvl),
    .PIN_OUT(pout), .PIN_OE_OUT(poe_o), .ANALOG_SEL_OUT(analog_input_sel), .PERIPH_DATA_IN(pdata),
    .PERIPH_OE_IN(poe), .PERIPH_DATA_OUT(pdo), .IRQ_EVENT_OUT(irq), .DS_WAKE_OUT(wake)
  );

  pfi_pin_model pins_u (
    .ext_level_in(ext), .pin_out_in(pout), .pin_oe_in(poe_o), .pin_level_out(pin_lvl)
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hrdy !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      err_count++;
      $display("ERROR %0t bus hang", $time);
      stop_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "bus response");
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e, m);
  endtask : rd

  function automatic logic [11:0] pfs(input int p);
    return PFS_BASE_OFS + 12'(4 * p);
  endfunction : pfs

  function automatic logic [11:0] icr(input int i);
    return IRQCR_BASE_OFS + 12'(4 * i);
  endfunction : icr

  // Low pulse of len cycles on pin p, events of irq k counted over win cycles
  task automatic pulse(input int p, input int len, input int k, input int win);
    cnt = 0;
    ds  = 0;
    oth = 0;
    lat = -1;
    ext[p] <= 1'b0;
    for (int c = 0; c < win; c++)
    begin
      @(posedge clk);
      if (c == len - 1)
        ext[p] <= 1'b1;
      if (irq[k] === 1'b1)
      begin
        cnt++;
        if (lat < 0)
          lat = c;
      end
      ds  += int'(wake[k] === 1'b1);
      oth += $countones(irq & ~(16'h0001 << k)) + $countones(wake & ~(16'h0001 << k));
      oth += int'($isunknown({irq, wake}));
    end
  endtask : pulse

  initial
  begin
    tick(4);
    rst_b <= 1'b1;
    wait_rdy();
    chk(poe_o, 32'h0000_0000, "oe after reset");
    chk(analog_input_sel, 32'h0000_0000, "analog after reset");
    rd(pfs(20), PFS_RESET, "pfs reset");
    rd(icr(0), 32'h0000_0000, "irqcr reset");
    rd(PIN_LEVEL_OFS, 32'hFFFF_FFFF, "pin levels idle");
    wr(pfs(0), 32'h0000_0005);
    wr(pfs(20), 32'h0000_0005);
    rd(pfs(20), 32'h0000_0000, "locked write");
    chk(poe_o, 32'h0000_0000, "locked oe");
    wr(WPROT_OFS, 32'h0000_0040);
    wr(pfs(20), 32'hFFFF_FFFF);
    rd(pfs(20), PFS_WMASK, "pfs fields");
    wr(pfs(20), 32'h0000_0000);
    wr(icr(0), 32'hFFFF_FFFF);
    rd(icr(0), {24'h00_0000, IRQCR_WMASK}, "irqcr fields");
    wr(12'h400, 32'hFFFF_FFFF);
    rd(12'h400, 32'h0000_0000, "unmapped");
    wr(pfs(20), 32'h0000_0005);
    tick(2);
    chk(poe_o, 32'h0010_0000, "direction out");
    chk(pout & 32'h0010_0000, 32'h0010_0000, "output data");
    wr(pfs(20), 32'h0000_0001);
    tick(2);
    chk(poe_o, 32'h0000_0000, "direction in");
    wr(pfs(21), 32'h0700_0000);
    wr(pfs(21), 32'h0701_0000);
    ext[21] <= 1'b0;
    tick(4);
    chk(pdo, 32'h0000_0000, "periph in low");
    rd(PIN_LEVEL_OFS, 32'hFFDF_FFFF, "pin level low");
    ext[21] <= 1'b1;
    tick(4);
    chk(pdo, 32'h0000_0080, "periph in high");
    poe[7] <= 1'b1;
    tick(3);
    chk(poe_o, 32'h0020_0000, "periph drives");
    chk(pout & 32'h0020_0000, 32'h0000_0000, "periph low");
    pdata[7] <= 1'b1;
    tick(3);
    chk(pout & 32'h0020_0000, 32'h0020_0000, "periph high");
    poe[7] <= 1'b0;
    wr(pfs(23), 32'h0000_8000);
    tick(2);
    chk(analog_input_sel, 32'h0080_0000, "analog select");
    wr(pfs(0), 32'h0000_8000);
    tick(2);
    chk(analog_input_sel, 32'h0080_0001, "analog pin 0");
    chk(poe_o & 32'h0000_0001, 32'h0000_0000, "analog undriven");
    wr(pfs(0), 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      wr(icr(i), 32'(i % 4));
      wr(pfs(i), 32'h0000_4000);
      tick(4);
      pulse(i, 10, i, 24);
      chk(cnt, exp_n[i % 4], "irq events");
      chk(ds + oth, 0, "stray events");
      if (i == 0)
        lat0 = lat;
      wr(pfs(i), 32'h0000_0000);
    end
    wr(icr(0), 32'h0000_0002);
    wr(pfs(16), 32'h0800_4000);
    wr(pfs(16), 32'h0801_4000);
    tick(4);
    pulse(16, 10, 0, 24);
    chk(cnt, 2, "twin events");
    chk(ds, 2, "wake events");
    chk(pdo, 32'h0000_0180, "shared periph");
    wr(pfs(16), 32'h0800_4000);
    wr(pfs(16), 32'h0000_0000);
    wr(pfs(0), 32'h0000_4000);
    for (int r = 0; r < 4; r++)
    begin
      wr(icr(0), 32'h0000_0082 | 32'(r << 4));
      tick(200);
      pulse(0, 2 * per[r], 0, 6 * per[r] + 16);
      chk(cnt, 0, "short pulse");
      pulse(0, 5 * per[r], 0, 9 * per[r] + 16);
      chk(cnt, 2, "long pulse");
      chk(ds + oth, 0, "filter strays");
      chk(32'(lat > lat0), 32'h0000_0001, "filter delay");
    end
    wr(icr(0), 32'h0000_0002);
    tick(4);
    pulse(0, 2, 0, 16);
    chk(cnt, 2, "filter bypass");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
